// ===== hdl/dbp_sram_port.sv
/*
 * Double-data-rate two-word burst SRAM port with its array, posted write
 * buffer, read bypass, echo clocks, read-valid flag, DLL lock tracking and
 * periodic impedance update.
 * Assumes the link clocks and every pin are slow against clock (200 MHz),
 * so the rising edge of each link clock is found by sampling.
 */
`include "dbp_defs.svh"

module dbp_sram_port #(
   parameter int ADDR_W = `DBP_ADDR_W,
   parameter int WORD_W = `DBP_WORD_W,
   parameter int LANES = `DBP_LANES,
   parameter int ZQ_PERIOD = `DBP_ZQ_PERIOD,
   parameter int LOCK_CYCLES = `DBP_LOCK_CYCLES,
   parameter int STOP_NS = `DBP_STOP_NS
) (
   // system
   input wire logic clock,
   input wire logic sys_rst,
   // link clocks
   input wire logic k_true,
   input wire logic k_comp,
   // command
   input wire logic rd_wr_sel,
   input wire logic cycle_select_n,
   input wire logic [LANES-1:0] lane_write_sel_n,
   input wire logic [ADDR_W-1:0] addr,
   // data pins
   input wire logic [WORD_W-1:0] dq_in,
   output logic [WORD_W-1:0] dq_out,
   output logic dq_oe,
   // echo and valid
   output logic echo_timing_true,
   output logic echo_timing_comp,
   output logic read_valid_flag,
   // dll and impedance
   input wire logic dll_bypass_n,
   output logic dll_locked,
   output logic impedance_update
);

   localparam int LANE_W = WORD_W / LANES;
   localparam int PAIR_L = 2 * LANES;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int SYNC_W = 5 + LANES + ADDR_W + WORD_W;
   localparam int STOP_CYC = (STOP_NS + `DBP_CLK_NS - 1) / `DBP_CLK_NS;
   localparam int IDLE_W = $clog2(STOP_CYC + 1);
   localparam int ZQ_W = $clog2(ZQ_PERIOD);
   localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);

   function automatic dbp_pkg::dbp_cmd_t decode_cmd(input logic sel_n, input logic rw);
      dbp_pkg::dbp_cmd_t c;
      c = dbp_pkg::CMD_NOP;
      if (!sel_n)
         c = rw ? dbp_pkg::CMD_RD : dbp_pkg::CMD_WR;
      return c;
   endfunction

   // synchronised pins
   logic [SYNC_W-1:0] sync_vec;
   logic kt_s, kc_s, rw_s, cyc_n_s, dll_on;
   logic [LANES-1:0] lane_n_s;
   logic [ADDR_W-1:0] addr_s;
   logic [WORD_W-1:0] dq_s;

   dbp_pin_sync #(
      .W(SYNC_W)
   ) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .pin_in({k_true, k_comp, rd_wr_sel, cycle_select_n, dll_bypass_n,
               lane_write_sel_n, addr, dq_in}),
      .sync_out(sync_vec)
   );

   assign {kt_s, kc_s, rw_s, cyc_n_s, dll_on, lane_n_s, addr_s, dq_s} = sync_vec;

   // link clock edges
   logic kt_prev_r, kc_prev_r;
   wire kr = kt_s & ~kt_prev_r;
   wire kcr = kc_s & ~kc_prev_r;

   // command decode, only looked at on a true-clock rise
   wire dbp_pkg::dbp_cmd_t cmd_w = decode_cmd(cyc_n_s, rw_s);
   wire rd_cmd = kr && (cmd_w == dbp_pkg::CMD_RD);
   wire wr_cmd = kr && (cmd_w == dbp_pkg::CMD_WR);

   // read pipeline: stage 0 holds last cycle's read, stage 1 the one before
   logic s0_v_r, s1_v_r;
   logic [ADDR_W-1:0] s0_a_r, s1_a_r;
   wire [1:0] lat_w = dll_on ? `DBP_LAT_DLL : `DBP_LAT_LEGACY;
   wire out_due = (lat_w == `DBP_LAT_DLL) ? s1_v_r : s0_v_r;
   wire [ADDR_W-1:0] out_addr = (lat_w == `DBP_LAT_DLL) ? s1_a_r : s0_a_r;

   // write path: address pending, first word staged, posted buffer
   logic wr_p_r, stg_v_r, wbuf_v_r;
   logic [ADDR_W-1:0] wr_a_r, stg_a_r, wbuf_a_r;
   logic [WORD_W-1:0] stg_d0_r;
   logic [LANES-1:0] stg_m0_r;
   logic [2*WORD_W-1:0] wbuf_d_r;
   logic [PAIR_L-1:0] wbuf_m_r;

   // the posted entry goes to the array on the next write cycle, or when a
   // newer write completes and needs the buffer
   wire commit = (wr_cmd | (kcr & stg_v_r)) & wbuf_v_r;
   wire byp_hit = wbuf_v_r && (wbuf_a_r == out_addr);

   // array, one flop store per lane of the word pair
   logic [2*WORD_W-1:0] arr_row;
   logic [2*WORD_W-1:0] fetch_w;

   genvar gi;
   generate
      for (gi = 0; gi < PAIR_L; gi++)
      begin : g_lane
         logic [LANE_W-1:0] lane_mem [DEPTH];
         always_ff @(posedge clock)
         begin
            if (commit && wbuf_m_r[gi])
               lane_mem[wbuf_a_r] <= wbuf_d_r[gi*LANE_W +: LANE_W];
         end
         assign arr_row[gi*LANE_W +: LANE_W] = lane_mem[out_addr];
         // unwritten lanes of the posted entry still come from the array
         assign fetch_w[gi*LANE_W +: LANE_W] = (byp_hit && wbuf_m_r[gi]) ?
            wbuf_d_r[gi*LANE_W +: LANE_W] : arr_row[gi*LANE_W +: LANE_W];
      end
   endgenerate

   // output side
   logic [WORD_W-1:0] dq_out_r, hi_word_r;
   logic dq_oe_r, burst_r, qv_r, echo_t_r, echo_c_r;

   // dll and impedance
   logic [IDLE_W-1:0] idle_cnt_r;
   logic [LOCK_W-1:0] lock_cnt_r;
   logic [ZQ_W-1:0] zq_cnt_r;
   logic locked_r, zq_pulse_r;
   wire k_stopped = (idle_cnt_r == IDLE_W'(STOP_CYC));
   wire lock_done = (lock_cnt_r == LOCK_W'(LOCK_CYCLES));
   wire zq_wrap = kr && (zq_cnt_r == ZQ_W'(ZQ_PERIOD - 1));

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         kt_prev_r <= `DBP_PREV_RST;
         kc_prev_r <= `DBP_PREV_RST;
         echo_t_r <= 1'b0;
         echo_c_r <= 1'b0;
      end
      else
      begin
         kt_prev_r <= kt_s;
         kc_prev_r <= kc_s;
         echo_t_r <= kt_s;
         echo_c_r <= kc_s;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         s0_v_r <= 1'b0;
         s1_v_r <= 1'b0;
         s0_a_r <= '0;
         s1_a_r <= '0;
      end
      else if (kr)
      begin
         s0_v_r <= rd_cmd;
         s1_v_r <= s0_v_r;
         s1_a_r <= s0_a_r;
         if (rd_cmd)
            s0_a_r <= addr_s;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         wr_p_r <= 1'b0;
         wr_a_r <= '0;
         stg_v_r <= 1'b0;
         stg_a_r <= '0;
         stg_d0_r <= '0;
         stg_m0_r <= '0;
      end
      else if (kr)
      begin
         wr_p_r <= wr_cmd;
         if (wr_cmd)
            wr_a_r <= addr_s;
         // first word one cycle after the command, read even if that
         // cycle is deselected; cycles after a non-write leave the pins unread
         stg_v_r <= wr_p_r;
         if (wr_p_r)
         begin
            stg_a_r <= wr_a_r;
            stg_d0_r <= dq_s;
            stg_m0_r <= ~lane_n_s;
         end
      end
      else if (kcr)
         stg_v_r <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         wbuf_v_r <= 1'b0;
         wbuf_a_r <= '0;
         wbuf_d_r <= '0;
         wbuf_m_r <= '0;
      end
      else if (kcr && stg_v_r)
      begin
         // second word joins the first; the pair is stored as one row
         wbuf_v_r <= 1'b1;
         wbuf_a_r <= stg_a_r;
         wbuf_d_r <= {dq_s, stg_d0_r};
         wbuf_m_r <= {~lane_n_s, stg_m0_r};
      end
      else if (commit)
         wbuf_v_r <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         dq_out_r <= '0;
         hi_word_r <= '0;
         dq_oe_r <= `DBP_OE_RST;
         burst_r <= 1'b0;
         qv_r <= `DBP_QV_RST;
      end
      else if (kr)
      begin
         dq_oe_r <= out_due;
         burst_r <= out_due;
         if (out_due)
         begin
            dq_out_r <= fetch_w[WORD_W-1:0];
            hi_word_r <= fetch_w[2*WORD_W-1:WORD_W];
         end
      end
      else if (kcr)
      begin
         // flag moves half a cycle ahead of the word it announces
         qv_r <= out_due;
         burst_r <= 1'b0;
         if (burst_r)
            dq_out_r <= hi_word_r;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         idle_cnt_r <= '0;
         lock_cnt_r <= '0;
         locked_r <= 1'b0;
         zq_cnt_r <= '0;
         zq_pulse_r <= 1'b0;
      end
      else
      begin
         if (kr || kcr)
            idle_cnt_r <= '0;
         else if (!k_stopped)
            idle_cnt_r <= idle_cnt_r + 1'b1;
         // a stall or a bypassed loop throws away the lock progress
         if (!dll_on || k_stopped)
            lock_cnt_r <= '0;
         else if (kr && !lock_done)
            lock_cnt_r <= lock_cnt_r + 1'b1;
         locked_r <= dll_on && !k_stopped && lock_done;
         if (kr)
            zq_cnt_r <= zq_wrap ? '0 : zq_cnt_r + 1'b1;
         zq_pulse_r <= zq_wrap;
      end
   end

   assign dq_out = dq_out_r;
   assign dq_oe = dq_oe_r;
   assign echo_timing_true = echo_t_r;
   assign echo_timing_comp = echo_c_r;
   assign read_valid_flag = qv_r;
   assign dll_locked = locked_r;
   assign impedance_update = zq_pulse_r;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   sequence s_read_issue;
      rd_cmd;
   endsequence

   sequence s_write_issue;
      wr_cmd;
   endsequence

   a_read_addr_latch: assert property (s_read_issue |=> s0_v_r && s0_a_r == $past(addr_s))
      else $error("read address not latched");

   a_write_addr_latch: assert property (s_write_issue |=> wr_p_r && wr_a_r == $past(addr_s))
      else $error("write address not latched");

   a_nop_no_access: assert property (kr && cyc_n_s |=> !s0_v_r && !wr_p_r)
      else $error("deselected cycle started an access");

   a_reset_tristate: assert property (@(posedge clock) disable iff (1'b0)
      sys_rst |=> !dq_oe_r && !read_valid_flag)
      else $error("outputs not tri-stated after reset");

   a_read_drives_word: assert property (kr && out_due |=> dq_oe_r && dq_out_r == $past(fetch_w[WORD_W-1:0]))
      else $error("first read word not driven");

   a_idle_tristate: assert property (kr && !out_due |=> !dq_oe_r)
      else $error("outputs not released after burst");

   a_second_word: assert property (kcr && burst_r |=> dq_out_r == $past(hi_word_r) && dq_oe_r)
      else $error("second read word not driven");

   a_valid_leads: assert property (kcr && out_due |=> read_valid_flag)
      else $error("read valid flag missing before data");

   a_echo_follows: assert property ($changed(kt_s) |=> echo_timing_true == $past(kt_s))
      else $error("echo clock does not follow true clock");

   a_posted_hold: assert property (wbuf_v_r && !commit && !(kcr && stg_v_r) |=> wbuf_v_r && $stable(wbuf_a_r))
      else $error("posted write lost before a write cycle");

   a_bypass_unlock: assert property (!dll_on |=> !dll_locked ##1 !dll_locked)
      else $error("lock shown with the loop bypassed");

   a_lock_count: assert property ($rose(dll_locked) |-> $past(lock_cnt_r) == LOCK_W'(LOCK_CYCLES))
      else $error("lock before the required clock count");

   a_zq_period: assert property (impedance_update |-> zq_cnt_r == '0 && $past(kr))
      else $error("impedance update off its period");

endmodule // dbp_sram_port

// ===== hdl/dbp_defs.svh
/*
 * Constants of the burst SRAM port: timing figures, latencies, reset values
 * and default geometry. Assumes it is included by its bare name.
 */
`ifndef DBP_DEFS_SVH
`define DBP_DEFS_SVH

`define DBP_CLK_NS 5
`define DBP_STOP_NS 30
`define DBP_ZQ_PERIOD 1024
`define DBP_LOCK_CYCLES 2048
`define DBP_LAT_DLL 2'h2
`define DBP_LAT_LEGACY 2'h1
`define DBP_WORD_W 18
`define DBP_LANES 2
`define DBP_ADDR_W 19
`define DBP_OE_RST 1'b0
`define DBP_QV_RST 1'b0
`define DBP_PREV_RST 1'b1

`endif

// ===== hdl/dbp_pkg.sv
/*
 * Types of the burst SRAM port.
 * Assumes nothing of its surroundings.
 */
package dbp_pkg;

   typedef enum logic [1:0]
   {
      CMD_NOP = 2'b00,
      CMD_RD = 2'b01,
      CMD_WR = 2'b10
   } dbp_cmd_t;

endpackage

// ===== hdl/dbp_pin_sync.sv
/*
 * Two-stage synchroniser for a bundle of pin inputs.
 * Assumes each bit is a level that stays put for several clock periods.
 */
module dbp_pin_sync #(
   parameter int W = 1
) (
   // system
   input wire logic clock,
   input wire logic sys_rst,
   // pins and synchronised copy
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         // pins idle high (parked clocks, deselected); a low start would fake an edge
         meta_r <= '1;
         sync_r <= '1;
      end
      else
      begin
         meta_r <= pin_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;

endmodule // dbp_pin_sync

// ===== dv/dbp_ctrl_model.sv
/*
 * Memory-controller model: makes the link clocks (parked high while run is low) and plays
 * queued commands, one per link cycle, with write words on both phases.
 * Assumes the bench fills q and reads back the half-cycle samples in seen.
 */
module dbp_ctrl_model #(
   parameter int AW = 4
) (
   // system
   input wire logic clock,
   input wire logic run,
   // link clocks
   output logic k_true,
   output logic k_comp,
   // command and write data
   output logic rd_wr_sel,
   output logic cycle_select_n,
   output logic [1:0] lane_write_sel_n,
   output logic [AW-1:0] addr,
   output logic [17:0] dq_in,
   // observed outputs
   input wire logic [17:0] dq_out,
   input wire logic dq_oe,
   input wire logic read_valid_flag,
   input wire logic echo_timing_true,
   input wire logic echo_timing_comp
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [AW+41:0] q[$];
   logic [21:0] seen[$];
   logic logging = 1'b0;
   logic kt = 1'b1;
   logic [AW+41:0] c_on = '0;
   logic [AW+41:0] c_prev = '0;

   initial
   begin
      {rd_wr_sel, cycle_select_n, lane_write_sel_n, addr, dq_in} = '1;
      #1.3;
      forever
      begin
         #62.5;
         kt = run ? ~kt : 1'b1;
      end
   end
   assign k_true = kt;
   assign k_comp = run ? ~kt : 1'b1;

   function automatic logic is_wr(input logic [AW+41:0] c);
      return c[AW+41 -: 2] == dbp_pkg::CMD_WR;
   endfunction

   // non-write phases get inverted data, never a helpful stale value
   task automatic put(input logic wr, input logic [17:0] d, input logic [1:0] m);
      dq_in <= wr ? d : ~dq_in;
      lane_write_sel_n <= wr ? m : ~lane_write_sel_n;
   endtask

   task automatic log_it;
      if (logging)
         seen.push_back({dq_oe, read_valid_flag, echo_timing_true, echo_timing_comp, dq_out});
   endtask

   // drive 30 ns after each pin edge, well clear of the design's sampling
   always @(posedge kt)
   begin
      repeat (6) @(posedge clock);
      logging = logging | (q.size() > 0);
      log_it();
      put(is_wr(c_prev), c_prev[35:18], c_prev[39:38]);
      c_prev = c_on;
      c_on = (q.size() > 0) ? q.pop_front() : '0;
      cycle_select_n <= c_on[AW+41 -: 2] == dbp_pkg::CMD_NOP;
      rd_wr_sel <= c_on[AW+41 -: 2] == dbp_pkg::CMD_RD;
      addr <= c_on[40 +: AW];
   end

   always @(posedge k_comp)
   begin
      repeat (6) @(posedge clock);
      log_it();
      put(is_wr(c_prev), c_prev[17:0], c_prev[37:36]);
   end
endmodule // dbp_ctrl_model

// ===== dv/dbp_sram_port_bench.sv
/*
 * Self-checking bench of the burst SRAM port driven by the controller model.
 * Assumes dbp_pkg, the port and the model are compiled first.
 */
module dbp_sram_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int AW = 4;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic run = 1'b1;
   logic dll_bypass_n = 1'b1;
   logic k_true, k_comp, rd_wr_sel, cycle_select_n, dq_oe, read_valid_flag;
   logic echo_timing_true, echo_timing_comp, dll_locked, impedance_update;
   logic [1:0] lane_write_sel_n;
   logic [AW-1:0] addr;
   logic [17:0] dq_in, dq_out;
   int bad_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int zq_count = 0;
   logic [35:0] mem [16];
   logic [AW+41:0] bq[$];

   always #2.5 clock = ~clock;

   dbp_ctrl_model #(.AW(AW)) ctl (.clock(clock), .run(run), .k_true(k_true),
      .k_comp(k_comp), .rd_wr_sel(rd_wr_sel), .cycle_select_n(cycle_select_n),
      .lane_write_sel_n(lane_write_sel_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .read_valid_flag(read_valid_flag),
      .echo_timing_true(echo_timing_true), .echo_timing_comp(echo_timing_comp));

   // short lock and update counts; stop time longer than a link half-period
   dbp_sram_port #(.ADDR_W(AW), .ZQ_PERIOD(8), .LOCK_CYCLES(8), .STOP_NS(200)) dut (
      .clock(clock), .sys_rst(sys_rst), .k_true(k_true), .k_comp(k_comp),
      .rd_wr_sel(rd_wr_sel), .cycle_select_n(cycle_select_n),
      .lane_write_sel_n(lane_write_sel_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .echo_timing_true(echo_timing_true),
      .echo_timing_comp(echo_timing_comp), .read_valid_flag(read_valid_flag),
      .dll_bypass_n(dll_bypass_n), .dll_locked(dll_locked),
      .impedance_update(impedance_update));

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (impedance_update === 1'b1)
         zq_count <= zq_count + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_k(input int n);
      repeat (n) @(posedge k_true);
      @(posedge clock);
   endtask

   task automatic cmd(input dbp_pkg::dbp_cmd_t op, input logic [AW-1:0] a,
      input logic [3:0] m, input logic [35:0] d);
      bq.push_back({op, a, m, d});
   endtask

   // plays the queued batch, then judges every half-cycle sample
   task automatic run_batch(input int lat);
      int n;
      int len;
      int j;
      logic [AW-1:0] a;
      logic [35:0] row;
      logic [21:0] s;
      logic [19:0] ex [64];
      n = bq.size();
      len = 2 * (n + lat + 3);
      foreach (ex[i])
         ex[i] = '0;
      for (int k = 0; k < n; k++)
      begin
         a = bq[k][40 +: AW];
         for (int l = 0; l < 4; l++)
            if (bq[k][AW+41 -: 2] == dbp_pkg::CMD_WR && !bq[k][36 + l])
               mem[a][9*l +: 9] = bq[k][9*l +: 9];
         row = mem[a];
         j = 2 * (lat + k);
         if (bq[k][AW+41 -: 2] == dbp_pkg::CMD_RD)
         begin
            ex[j + 1][18] = 1'b1;
            ex[j + 2] = {2'b11, row[17:0]};
            ex[j + 3] = {2'b10, row[35:18]};
         end
      end
      ctl.seen.delete();
      ctl.logging = 1'b0;
      foreach (bq[k])
         ctl.q.push_back(bq[k]);
      bq.delete();
      while (ctl.seen.size() < len)
         @(posedge clock);
      for (int h = 0; h < len; h++)
      begin
         s = ctl.seen[h];
         check("oe_flag", 36'(s[21:20]), 36'(ex[h][19:18]));
         check("echo", 36'(s[19:18]), (h % 2 == 0) ? 36'h2 : 36'h1);
         if (ex[h][19])
            check("dq", 36'(s[17:0]), 36'(ex[h][17:0]));
      end
   endtask

   task automatic t_full;
      cmd(dbp_pkg::CMD_WR, 4'h1, 4'h0, 36'h1a2b3c4d5);
      cmd(dbp_pkg::CMD_WR, 4'h2, 4'h0, 36'h2b3c4d5e6);
      cmd(dbp_pkg::CMD_WR, 4'h3, 4'h0, 36'h3c4d5e6f7);
      cmd(dbp_pkg::CMD_RD, 4'h3, 4'h0, 36'h0);
      cmd(dbp_pkg::CMD_RD, 4'h1, 4'h0, 36'h0);
      run_batch(2);
   endtask

   // masked writes, reads of a posted row, two idle slots before each write after the first
   task automatic t_mask;
      cmd(dbp_pkg::CMD_WR, 4'h2, 4'h6, 36'h0f0f0f0f0);
      cmd(dbp_pkg::CMD_RD, 4'h2, 4'h0, 36'h0);
      cmd(dbp_pkg::CMD_RD, 4'h1, 4'h0, 36'h0);
      for (int i = 0; i < 2; i++)
         cmd(dbp_pkg::CMD_NOP, 4'h0, 4'h0, 36'h0);
      cmd(dbp_pkg::CMD_WR, 4'h3, 4'h9, 36'h5a5a5a5a5);
      cmd(dbp_pkg::CMD_RD, 4'h2, 4'h0, 36'h0);
      cmd(dbp_pkg::CMD_RD, 4'h3, 4'h0, 36'h0);
      for (int i = 0; i < 2; i++)
         cmd(dbp_pkg::CMD_NOP, 4'h0, 4'h0, 36'h0);
      cmd(dbp_pkg::CMD_WR, 4'h1, 4'hf, 36'hfffffffff);
      cmd(dbp_pkg::CMD_RD, 4'h1, 4'h0, 36'h0);
      run_batch(2);
   endtask

   task automatic t_lat1;
      dll_bypass_n <= 1'b0;
      wait_k(2);
      check("lock", 36'(dll_locked), 36'h0);
      for (int i = 1; i < 4; i++)
         cmd(dbp_pkg::CMD_RD, 4'(i), 4'h0, 36'h0);
      run_batch(1);
      dll_bypass_n <= 1'b1;
      wait_k(2);
   endtask

   task automatic t_zq;
      int z0;
      @(posedge k_true);
      repeat (6) @(posedge clock);
      z0 = zq_count;
      repeat (16) @(posedge k_true);
      repeat (6) @(posedge clock);
      check("zq", 36'(zq_count - z0), 36'h2);
   endtask

   task automatic t_dll;
      wait_k(12);
      check("lock", 36'(dll_locked), 36'h1);
      run <= 1'b0;
      repeat (120) @(posedge clock);
      check("lock", 36'(dll_locked), 36'h0);
      check("echo", 36'({echo_timing_true, echo_timing_comp}), 36'h3);
      check("oe", 36'(dq_oe), 36'h0);
      run <= 1'b1;
      wait_k(12);
      check("lock", 36'(dll_locked), 36'h1);
   endtask

   initial
   begin
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (5) @(posedge clock);
      check("oe", 36'(dq_oe), 36'h0);
      check("flag", 36'(read_valid_flag), 36'h0);
      wait_k(2);
      t_full();
      t_mask();
      t_lat1();
      t_zq();
      t_dll();
      tally_and_finish();
   end
endmodule // dbp_sram_port_bench
